// File: pmx_pkg.sv
// Shared constants and types for the MAC-side PHY data interface
package pmx_pkg;
    // Interface modes
    typedef enum logic [2:0] {
        PMX_MODE_MII = 3'b001,
        PMX_MODE_RMII = 3'b010,
        PMX_MODE_RGMII = 3'b100
    } pmx_mode_t;

    // Core clock 250 MHz
    localparam int unsigned PMX_CLK_HZ = 250000000;
    localparam int unsigned PMX_FAST_HZ = 25000000;
    localparam int unsigned PMX_SLOW_HZ = 2500000;
    // Half periods of the link clock, in core cycles
    localparam int unsigned PMX_HALF_FAST = PMX_CLK_HZ / PMX_FAST_HZ / 2;
    localparam int unsigned PMX_HALF_SLOW = PMX_CLK_HZ / PMX_SLOW_HZ / 2;
    localparam int unsigned PMX_DIV_W = 8;

    // Wait after reset release, least time before the straps are read
    localparam int unsigned PMX_RESET_NS = 1000;
    localparam int unsigned PMX_RESET_CYC = (PMX_RESET_NS * (PMX_CLK_HZ / 1000000) + 999) / 1000;

    // Strap defaults: address bits 4..1 low, bit 0 high
    localparam logic [4:0] PMX_STRAP_DEFAULT = 5'h01;
    localparam logic [3:0] PMX_ERR_NIBBLE = 4'he;
endpackage

// File: pmx_if.sv
// Interface joining the transceiver end and the MAC end
`timescale 1ns/10ps
interface pmx_if;
    logic tx_clk;
    logic tx_clk_oe;
    logic mac_tx_clk;
    logic tx_en;
    logic tx_er;
    logic [3:0] tx_d;
    logic rx_clk;
    logic rx_dv;
    logic rx_er;
    logic [3:0] rx_d_o;
    logic [3:0] rx_d_oe;
    logic [3:0] rx_d_i;
    logic crs;
    logic col_o;
    logic col_oe;
    logic col_i;

    modport phy (
        output tx_clk, tx_clk_oe, rx_clk, rx_dv, rx_er, rx_d_o, rx_d_oe, crs, col_o, col_oe,
        input mac_tx_clk, tx_en, tx_er, tx_d, rx_d_i, col_i
    );
    modport mac (
        input tx_clk, tx_clk_oe, rx_clk, rx_dv, rx_er, rx_d_o, crs, col_o,
        output mac_tx_clk, tx_en, tx_er, tx_d
    );
endinterface

// File: pmx_phy.sv
// Transceiver end: MAC-facing MII / RMII / RGMII data interface
`timescale 1ns/10ps

// Functional notes
// - MII transmit clock 25 or 2.5 MHz
// - MII transmit clock phase fixed to reference
// - RGMII: MAC sources transmit clock
// - Transmit enable sampled on rising edge
// - RGMII control: enable rising, error falling
// - Transmit data sampled on rising edge
// - Receive clock 25 or 2.5 MHz, not RMII
// - Receive valid marks data, ignores carrier
// - RGMII receive control: valid rising, error falling
// - Receive error flags error symbol
// - Corrupt delivered data on receive error
// - Receive data presented on rising edge
// - Receive data and collision pins strap address, default 0x01
// - Carrier sense; RMII merges receive valid
// - Collision only half duplex, both busy
// - Reset held one microsecond reinitialises
module pmx_phy #(
    parameter int unsigned HALF_FAST = pmx_pkg::PMX_HALF_FAST,
    parameter int unsigned HALF_SLOW = pmx_pkg::PMX_HALF_SLOW
) (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    pmx_if.phy LINK,
    input wire pmx_pkg::pmx_mode_t MODE,
    input wire logic SPEED_100,
    input wire logic FULL_DUPLEX,
    input wire logic LINE_RX_VALID,
    input wire logic [3:0] LINE_RX_DATA,
    input wire logic LINE_RX_ERROR,
    input wire logic LINE_RX_CARRIER,
    output logic LINE_RX_READY,
    output logic TX_VALID,
    output logic [3:0] TX_DATA,
    output logic TX_ERROR,
    output logic [4:0] PHY_ADDRESS_STRAP,
    output logic STRAP_DONE
);
    localparam int unsigned RCW = pmx_pkg::PMX_DIV_W;

    // Reset release counter: straps wait PMX_RESET_CYC cycles after release
    logic [RCW-1:0] rst_cnt_q;
    logic rst_ok_q;
    logic [RCW-1:0] div_q;
    logic lclk_q;
    logic lclk_prev_q;
    logic strap_q;
    logic [1:0] buf_cnt_q;
    logic [4:0] buf_d_q [2];
    logic buf_wr_q;
    logic buf_rd_q;
    // Registered so the ready output comes straight from a flip-flop
    logic rdy_q;
    logic rx_dv_q;
    logic rx_er_q;
    logic [3:0] rx_d_q;
    logic crs_q;
    logic col_q;
    logic tx_v_q;
    logic tx_e_q;
    logic [3:0] tx_d_q;
    logic [4:0] addr_q;

    wire is_mii = (MODE == pmx_pkg::PMX_MODE_MII);
    wire is_rmii = (MODE == pmx_pkg::PMX_MODE_RMII);
    wire is_rgmii = (MODE == pmx_pkg::PMX_MODE_RGMII);
    wire [RCW-1:0] half = SPEED_100 ? RCW'(HALF_FAST - 1) : RCW'(HALF_SLOW - 1);
    wire div_wrap = (div_q >= half);
    // Link clock edges in the core domain
    wire lclk_rise = lclk_q & ~lclk_prev_q;
    wire lclk_fall = ~lclk_q & lclk_prev_q;
    // RMII has a shared reference: sample every core-derived link period on rise as well
    wire tx_src = is_rgmii ? LINK.mac_tx_clk : lclk_q;
    logic tx_src_prev_q;
    wire tx_rise = tx_src & ~tx_src_prev_q;
    wire tx_fall = ~tx_src & tx_src_prev_q;
    wire buf_full = (buf_cnt_q == 2'd2);
    wire buf_empty = (buf_cnt_q == 2'd0);
    wire push = LINE_RX_VALID & ~buf_full & strap_q;
    wire pop = lclk_rise & ~buf_empty;
    wire [4:0] head = buf_d_q[buf_rd_q];
    wire [1:0] buf_cnt_d = buf_cnt_q + {1'b0, push} - {1'b0, pop};
    // Next receive valid, shared so the RMII carrier pin moves with it
    wire rx_dv_d = lclk_rise ? ~buf_empty : ((lclk_fall && is_rgmii) ? rx_er_q : rx_dv_q);

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_cnt_q <= '0;
            rst_ok_q <= 1'b0;
        end else if (!rst_ok_q) begin
            rst_cnt_q <= rst_cnt_q + RCW'(1);
            rst_ok_q <= (rst_cnt_q >= RCW'(pmx_pkg::PMX_RESET_CYC - 1));
        end
    end

    // One divider for both link clocks keeps their phase fixed to the core clock
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            div_q <= '0;
            lclk_q <= 1'b0;
            lclk_prev_q <= 1'b0;
            tx_src_prev_q <= 1'b0;
        end else begin
            div_q <= div_wrap ? '0 : div_q + RCW'(1);
            lclk_q <= div_wrap ? ~lclk_q : lclk_q;
            lclk_prev_q <= lclk_q;
            tx_src_prev_q <= tx_src;
        end
    end

    // Straps are read once, after reset release, before any strap pin is driven
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            strap_q <= 1'b0;
            addr_q <= pmx_pkg::PMX_STRAP_DEFAULT;
        end else if (!strap_q && rst_ok_q) begin
            strap_q <= 1'b1;
            addr_q <= {LINK.rx_d_i, LINK.col_i};
        end
    end

    // Two-entry buffer between the line decoder and the link clock
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            buf_cnt_q <= 2'd0;
            buf_wr_q <= 1'b0;
            buf_rd_q <= 1'b0;
            rdy_q <= 1'b0;
            buf_d_q[0] <= '0;
            buf_d_q[1] <= '0;
        end else begin
            if (push) begin
                buf_d_q[buf_wr_q] <= {LINE_RX_ERROR, LINE_RX_DATA};
                buf_wr_q <= ~buf_wr_q;
            end
            if (pop) begin
                buf_rd_q <= ~buf_rd_q;
            end
            buf_cnt_q <= buf_cnt_d;
            // Same value as not full and straps taken, one cycle early
            rdy_q <= (buf_cnt_d != 2'd2) & (strap_q | rst_ok_q);
        end
    end

    // Receive outputs change on the link clock rise; the MAC samples them at the next rise
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rx_dv_q <= 1'b0;
            rx_er_q <= 1'b0;
            rx_d_q <= '0;
        end else begin
            rx_dv_q <= rx_dv_d;
            if (lclk_rise) begin
                rx_er_q <= ~buf_empty & head[4];
                rx_d_q <= buf_empty ? 4'h0 : (head[4] ? pmx_pkg::PMX_ERR_NIBBLE : head[3:0]);
                if (is_rmii) begin
                    rx_d_q[3:2] <= 2'b00;
                end
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            crs_q <= 1'b0;
            col_q <= 1'b0;
        end else begin
            crs_q <= is_rmii ? (LINE_RX_CARRIER | rx_dv_d) : (LINE_RX_CARRIER | tx_v_q);
            col_q <= ~FULL_DUPLEX & ~is_rmii & LINE_RX_CARRIER & tx_v_q;
        end
    end

    // Transmit capture: enable and data on rise, RGMII error on fall
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            tx_v_q <= 1'b0;
            tx_e_q <= 1'b0;
            tx_d_q <= '0;
        end else if (tx_rise) begin
            tx_v_q <= LINK.tx_en;
            tx_d_q <= is_rmii ? {2'b00, LINK.tx_d[1:0]} : LINK.tx_d;
            tx_e_q <= is_rgmii ? 1'b0 : LINK.tx_er;
        end else if (tx_fall && is_rgmii) begin
            tx_e_q <= LINK.tx_en;
        end
    end

    assign LINE_RX_READY = rdy_q;
    assign LINK.tx_clk = lclk_q;
    assign LINK.tx_clk_oe = is_mii & strap_q;
    assign LINK.rx_clk = is_rmii ? 1'b0 : lclk_q;
    assign LINK.rx_dv = rx_dv_q;
    assign LINK.rx_er = is_rgmii ? 1'b0 : rx_er_q;
    assign LINK.rx_d_o = rx_d_q;
    assign LINK.rx_d_oe = {4{strap_q}};
    assign LINK.crs = crs_q;
    assign LINK.col_o = col_q;
    assign LINK.col_oe = strap_q & ~is_rmii;
    assign TX_VALID = tx_v_q;
    assign TX_ERROR = tx_e_q;
    assign TX_DATA = tx_d_q;
    assign PHY_ADDRESS_STRAP = addr_q;
    assign STRAP_DONE = strap_q;
endmodule // pmx_phy

// File: pmx_mac.sv
// MAC end: drives transmit lines, samples receive lines
`timescale 1ns/10ps
module pmx_mac #(
    parameter int unsigned HALF_FAST = pmx_pkg::PMX_HALF_FAST,
    parameter int unsigned HALF_SLOW = pmx_pkg::PMX_HALF_SLOW
) (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    pmx_if.mac LINK,
    input wire pmx_pkg::pmx_mode_t MODE,
    input wire logic SPEED_100,
    input wire logic TX_VALID,
    input wire logic [3:0] TX_DATA,
    input wire logic TX_ERROR,
    output logic TX_READY,
    output logic RX_VALID,
    output logic [3:0] RX_DATA,
    output logic RX_ERROR
);
    localparam int unsigned DW = pmx_pkg::PMX_DIV_W;
    logic [DW-1:0] div_q;
    logic clk_q;
    logic ref_prev_q;
    logic rx_prev_q;
    logic tx_en_q;
    logic tx_er_q;
    logic tx_err_hold_q;
    logic [3:0] tx_d_q;
    logic rx_v_q;
    logic rx_e_q;
    logic [3:0] rx_d_q;
    // RGMII valid half and data, held until the error half arrives
    logic rx_hold_v_q;
    logic [3:0] rx_hold_d_q;

    wire is_rgmii = (MODE == pmx_pkg::PMX_MODE_RGMII);
    wire is_rmii = (MODE == pmx_pkg::PMX_MODE_RMII);
    wire [DW-1:0] half = SPEED_100 ? DW'(HALF_FAST - 1) : DW'(HALF_SLOW - 1);
    wire div_wrap = (div_q >= half);
    // In RGMII this end makes the transmit clock; otherwise it follows the device's
    wire ref_clk = is_rgmii ? clk_q : LINK.tx_clk;
    wire ref_fall = ~ref_clk & ref_prev_q;
    wire ref_rise = ref_clk & ~ref_prev_q;
    wire rx_rise = LINK.rx_clk & ~rx_prev_q;
    wire rx_fall = ~LINK.rx_clk & rx_prev_q;
    wire rx_tick = is_rmii ? ref_rise : rx_rise;

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            div_q <= '0;
            clk_q <= 1'b0;
            ref_prev_q <= 1'b0;
            rx_prev_q <= 1'b0;
        end else begin
            div_q <= div_wrap ? '0 : div_q + DW'(1);
            clk_q <= div_wrap ? ~clk_q : clk_q;
            ref_prev_q <= ref_clk;
            rx_prev_q <= LINK.rx_clk;
        end
    end

    // Launch on the falling edge so the device sees stable lines at its rise
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            tx_en_q <= 1'b0;
            tx_er_q <= 1'b0;
            tx_err_hold_q <= 1'b0;
            tx_d_q <= '0;
        end else if (ref_fall) begin
            tx_en_q <= TX_VALID;
            tx_d_q <= is_rmii ? {2'b00, TX_DATA[1:0]} : TX_DATA;
            tx_er_q <= TX_VALID & TX_ERROR;
            tx_err_hold_q <= TX_VALID & TX_ERROR;
        end else if (ref_rise && is_rgmii) begin
            tx_en_q <= tx_err_hold_q;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rx_v_q <= 1'b0;
            rx_e_q <= 1'b0;
            rx_d_q <= '0;
            rx_hold_v_q <= 1'b0;
            rx_hold_d_q <= '0;
        end else if (rx_tick) begin
            rx_v_q <= is_rgmii ? rx_hold_v_q : LINK.rx_dv;
            rx_d_q <= is_rgmii ? rx_hold_d_q : LINK.rx_d_o;
            rx_e_q <= is_rgmii ? LINK.rx_dv : LINK.rx_er;
        end else if (rx_fall && is_rgmii) begin
            rx_hold_v_q <= LINK.rx_dv;
            rx_hold_d_q <= LINK.rx_d_o;
        end
    end

    assign TX_READY = ref_fall;
    assign LINK.mac_tx_clk = clk_q;
    assign LINK.tx_en = tx_en_q;
    assign LINK.tx_er = tx_er_q;
    assign LINK.tx_d = tx_d_q;
    assign RX_VALID = rx_v_q;
    assign RX_DATA = rx_d_q;
    assign RX_ERROR = rx_e_q;
endmodule // pmx_mac

// File: pmx_chk.sv
// Protocol checker for the transceiver-to-MAC link
`timescale 1ns/10ps
module pmx_chk #(
    parameter int unsigned HALF_FAST = 5,
    parameter int unsigned HALF_SLOW = 50
) (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire pmx_pkg::pmx_mode_t MODE,
    input wire logic SPEED_100,
    input wire logic FULL_DUPLEX,
    input wire logic tx_clk,
    input wire logic rx_clk,
    input wire logic rx_dv,
    input wire logic rx_er,
    input wire logic [3:0] rx_d_o,
    input wire logic [3:0] rx_d_oe,
    input wire logic crs,
    input wire logic col_o,
    input wire logic col_oe
);
    localparam int P_FAST = 2 * HALF_FAST;
    localparam int P_SLOW = 2 * HALF_SLOW;
    wire is_mii = (MODE == pmx_pkg::PMX_MODE_MII);
    wire is_rmii = (MODE == pmx_pkg::PMX_MODE_RMII);
    wire rx_clk_used = !is_rmii;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    txclk_fast_a: assert property (is_mii && SPEED_100 && $rose(tx_clk) |-> ##P_FAST $rose(tx_clk))
        else $error("tx clock period wrong at 100 Mb");
    txclk_slow_a: assert property (is_mii && !SPEED_100 && $rose(tx_clk) |-> ##P_SLOW $rose(tx_clk))
        else $error("tx clock period wrong at 10 Mb");
    rxclk_fast_a: assert property (rx_clk_used && SPEED_100 && $rose(rx_clk) |-> ##P_FAST $rose(rx_clk))
        else $error("rx clock period wrong");
    // Shared pins must stay released for the first 8 cycles after reset release
    strap_hold_a: assert property ($rose(RST_N) |-> (rx_d_oe == 4'h0 && !col_oe) [*8])
        else $error("strap pins driven too early");
    col_fdx_a: assert property (FULL_DUPLEX |-> !col_o)
        else $error("collision in full duplex");
    col_cause_a: assert property (col_o |-> crs && !FULL_DUPLEX)
        else $error("collision without busy medium");
    crs_dv_a: assert property (is_rmii && rx_dv |-> crs)
        else $error("rmii carrier misses receive valid");
    rx_corrupt_a: assert property (is_mii && rx_er |-> rx_d_o == pmx_pkg::PMX_ERR_NIBBLE)
        else $error("error word not corrupted");
    rmii_upper_a: assert property (is_rmii && rx_dv |-> rx_d_o[3:2] == 2'h0)
        else $error("rmii upper receive bits set");

    cover property (is_rmii && rx_dv);
    cover property (col_o);
    cover property (is_mii && rx_er);
endmodule // pmx_chk

// File: tb.sv
// Testbench: transceiver end and MAC end joined back to back
`timescale 1ns/10ps
module tb;
    localparam int HF = 5;
    localparam int HS = 10;
    logic CORE_CLK = 1'b0;
    logic RST_N = 1'b0;
    pmx_pkg::pmx_mode_t mode = pmx_pkg::PMX_MODE_MII;
    logic spd = 1'b1, fdx = 1'b1, lv = 1'b0, le = 1'b0, car = 1'b0, mv = 1'b0, me = 1'b0;
    logic [3:0] ld = 4'h0, md = 4'h0;
    logic lrdy, ptv, pte, sdone, trdy, rv, re;
    logic [3:0] ptd, rd;
    logic [4:0] strap;
    logic [4:0] ext_strap = 5'h01;
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    pmx_if link();
    // Released strap pins show the board straps, by default the pull levels
    assign link.rx_d_i = (link.rx_d_oe & link.rx_d_o) | (~link.rx_d_oe & ext_strap[4:1]);
    assign link.col_i = link.col_oe ? link.col_o : ext_strap[0];
    pmx_phy #(.HALF_FAST(HF), .HALF_SLOW(HS)) pmx_phy_i (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .LINK(link),
        .MODE(mode), .SPEED_100(spd), .FULL_DUPLEX(fdx), .LINE_RX_VALID(lv),
        .LINE_RX_DATA(ld), .LINE_RX_ERROR(le), .LINE_RX_CARRIER(car), .LINE_RX_READY(lrdy), .TX_VALID(ptv),
        .TX_DATA(ptd), .TX_ERROR(pte), .PHY_ADDRESS_STRAP(strap), .STRAP_DONE(sdone));
    pmx_mac #(.HALF_FAST(HF), .HALF_SLOW(HS)) pmx_mac_i (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .LINK(link),
        .MODE(mode), .SPEED_100(spd), .TX_VALID(mv), .TX_DATA(md), .TX_ERROR(me), .TX_READY(trdy),
        .RX_VALID(rv), .RX_DATA(rd), .RX_ERROR(re));
    pmx_chk #(.HALF_FAST(HF), .HALF_SLOW(HS)) pmx_chk_i (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .MODE(mode),
        .SPEED_100(spd), .FULL_DUPLEX(fdx), .tx_clk(link.tx_clk), .rx_clk(link.rx_clk), .rx_dv(link.rx_dv),
        .rx_er(link.rx_er), .rx_d_o(link.rx_d_o), .rx_d_oe(link.rx_d_oe), .crs(link.crs),
        .col_o(link.col_o), .col_oe(link.col_oe));

    always #2 CORE_CLK = ~CORE_CLK;

    task automatic final_report();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Whole run needs about 1900 cycles
    always @(posedge CORE_CLK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            $display("[FAIL] %0t timeout", $time);
            error_cnt++;
            final_report();
        end
    end

    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    function automatic logic [3:0] msk();
        return (mode == pmx_pkg::PMX_MODE_RMII) ? 4'h3 : 4'hf;
    endfunction

    task automatic restart(input pmx_pkg::pmx_mode_t m, input logic s, input logic f, input logic [4:0] a);
        @(negedge CORE_CLK);
        RST_N = 1'b0;
        mode = m;
        spd = s;
        fdx = f;
        ext_strap = a;
        repeat (10) @(negedge CORE_CLK);
        RST_N = 1'b1;
        repeat (260) @(negedge CORE_CLK);
        chk(sdone === 1'b1 && strap === a, "strap address");
    endtask

    // Four words pushed back to back, so the two-entry buffer must refuse one
    task automatic rx_burst(input logic err);
        logic [3:0] w[4];
        logic [3:0] last;
        logic full;
        int n;
        int k;
        w = '{4'h5, 4'h6, 4'h7, 4'h9};
        full = 1'b0;
        n = 0;
        k = 0;
        last = rd;
        car = !err;
        fork
            begin
                for (int i = 0; i < 4; i++) begin
                    lv = 1'b1;
                    ld = w[i];
                    le = err && i == 1;
                    while (lrdy !== 1'b1) begin
                        full = 1'b1;
                        @(negedge CORE_CLK);
                    end
                    @(negedge CORE_CLK);
                end
                lv = 1'b0;
                le = 1'b0;
            end
            while (n < 4 && k < 800) begin
                @(negedge CORE_CLK);
                k++;
                if (rv === 1'b1 && rd !== last) begin
                    last = rd;
                    chk(rd === (((err && n == 1) ? pmx_pkg::PMX_ERR_NIBBLE : w[n]) & msk()), "rx data");
                    chk(re === (err && n == 1), "rx error flag");
                    n++;
                end
            end
        join
        chk(n == 4 && full, "rx words or refusal");
        car = 1'b0;
        repeat (4 * HS + 4) @(negedge CORE_CLK);
        chk(link.rx_dv === 1'b0, "rx valid idle");
    endtask

    task automatic tx_word(input logic [3:0] d, input logic err, input logic col_exp);
        int k;
        logic col;
        logic perr;
        k = 0;
        col = 1'b0;
        mv = 1'b1;
        md = d;
        me = err;
        while (trdy !== 1'b1 && k < 400) begin
            @(negedge CORE_CLK);
            k++;
        end
        @(negedge CORE_CLK);
        mv = 1'b0;
        me = 1'b0;
        while (ptv !== 1'b1 && k < 800) begin
            @(negedge CORE_CLK);
            col |= link.col_o;
            k++;
        end
        // RGMII error lands at the falling half, so gather it over the word
        perr = pte;
        chk(ptd === (d & msk()), "tx data");
        while (ptv === 1'b1 && k < 1200) begin
            @(negedge CORE_CLK);
            col |= link.col_o;
            if (ptv === 1'b1) begin
                perr |= pte;
            end
            k++;
        end
        chk(perr === err, "tx error");
        chk(ptv === 1'b0 && col === col_exp, "tx end or collision");
    endtask

    initial begin
        pmx_pkg::pmx_mode_t m[3];
        m = '{pmx_pkg::PMX_MODE_MII, pmx_pkg::PMX_MODE_RMII, pmx_pkg::PMX_MODE_RGMII};
        for (int i = 0; i < 3; i++) begin
            restart(m[i], 1'b1, 1'b1, 5'h01);
            rx_burst(1'b0);
            rx_burst(1'b1);
            tx_word(4'ha, 1'b0, 1'b0);
            tx_word(4'h5, m[i] == pmx_pkg::PMX_MODE_RGMII, 1'b0);
        end
        // Board straps away from the pull levels must be latched as given
        restart(pmx_pkg::PMX_MODE_MII, 1'b0, 1'b0, 5'h16);
        car = 1'b1;
        tx_word(4'h3, 1'b0, 1'b1);
        car = 1'b0;
        rx_burst(1'b0);
        final_report();
    end
endmodule // tb
